//--- include/temp_loop_defs.svh
// Overview of operation
// - Four independent loops, each with own target, gains and outputs.
// - All four channels processed once per 250 ms or 500 ms cycle.
// - Each loop selects standard heating, standard cooling or heating-cooling; mixing allowed.
// - Forward action (cooling): output rises as temperature rises above target.
// - Reverse action (heating): output rises as temperature falls below target.
// - Derivative term passes a first-order lag, updated every sample.
// - Derivative uses measured temperature change, not deviation change.
// - Response fast, normal or slow weights target only, not disturbance.
// - Peak suppression staggers channel turn-on moments so none coincide.
// - Grouped loops ramp together and reach their targets simultaneously.
// - Integral windup limiter feeds back clamp excess to the integrator.
// - One-point compensation adds a fraction of full scale.
// - Two-point compensation interpolates linearly through calibration points.
// - Optional first-order lag filter on each measured temperature.
// - Settings saved to non-volatile store on command, restored after reset.
// - Input-only mode measures and filters, drives no outputs.
// - Output level clamped to -5.0 % .. 105.0 %.
// - Heating-cooling loop drives two outputs; standard loop drives one.
`ifndef TEMP_LOOP_DEFS_SVH
`define TEMP_LOOP_DEFS_SVH
`define CLK_MHZ         250
`define FAST_SAMPLE_MS  250
`define SLOW_SAMPLE_MS  500
`define FAST_SAMPLE_CYC (`FAST_SAMPLE_MS * 1000 * `CLK_MHZ)
`define SLOW_SAMPLE_CYC (`SLOW_SAMPLE_MS * 1000 * `CLK_MHZ)
`define OUT_TICK_US     1000
`define OUT_TICK_CYC    (`OUT_TICK_US * `CLK_MHZ)
`define OUT_PERIOD      10'h3e8
`define OUT_LAST        10'h3e7
`define OUT_STAGGER     10'h0fa
`define MV_LO           (-32'sh32)
`define MV_HI           32'sh41a
`define RISE_SH         6
`define RISE_STEPS      7'h40
`define KP_SH           8
`define Q15_SH          15
`define ACC_SH          16
`endif

//--- include/temp_loop_pkg.sv
package temp_loop_pkg;
  typedef enum logic [1:0] {
    CM_HEAT     = 2'h0,
    CM_COOL     = 2'h1,
    CM_HEATCOOL = 2'h2
  } ctl_mode_t;
  typedef enum logic [1:0] {
    RESP_FAST   = 2'h0,
    RESP_NORMAL = 2'h1,
    RESP_SLOW   = 2'h2
  } resp_t;
  typedef enum logic [1:0] {
    COMP_NONE   = 2'h0,
    COMP_ONE_PT = 2'h1,
    COMP_TWO_PT = 2'h2
  } comp_t;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_COMP  = 6'h02,
    ST_FILT  = 6'h04,
    ST_PID   = 6'h08,
    ST_CLAMP = 6'h10,
    ST_OUT   = 6'h20
  } seq_state_t;
endpackage

//--- include/loop_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface loop_link_if;
  logic            ce;
  logic            slow_sel;
  logic            peak_sup;
  logic            sample_tick;
  logic            out_tick;
  logic [3:0][10:0] duty_h;
  logic [3:0][10:0] duty_c;
  modport timer (input ce, slow_sel, output sample_tick, out_tick);
  modport pwm   (input ce, out_tick, peak_sup, duty_h, duty_c);
  modport core  (output ce, slow_sel, peak_sup, duty_h, duty_c, input sample_tick);
endinterface
`default_nettype wire

//--- logic/sample_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "temp_loop_defs.svh"
module sample_timer #(
  parameter int unsigned FAST_CYC = `FAST_SAMPLE_CYC,
  parameter int unsigned SLOW_CYC = `SLOW_SAMPLE_CYC,
  parameter int unsigned TICK_CYC = `OUT_TICK_CYC
) (
  input  wire logic   ref_clk,
  input  wire logic   rst,
  loop_link_if.timer  link
);
  typedef struct packed {
    logic [26:0] cnt;
    logic [17:0] tcnt;
    logic        st;
    logic        ot;
  } timer_state_t;
  timer_state_t s_r, s_nxt;
  always_comb begin
    s_nxt = s_r;
    if (link.ce) begin
      s_nxt.st = 1'b0;
      s_nxt.ot = 1'b0;
      if (s_r.cnt >= 27'(link.slow_sel ? SLOW_CYC - 1 : FAST_CYC - 1)) begin
        s_nxt.cnt = 27'h0;
        s_nxt.st  = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + 27'h1;
      end
      if (s_r.tcnt >= 18'(TICK_CYC - 1)) begin
        s_nxt.tcnt = 18'h0;
        s_nxt.ot   = 1'b1;
      end else begin
        s_nxt.tcnt = s_r.tcnt + 18'h1;
      end
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign link.sample_tick = s_r.st;
  assign link.out_tick    = s_r.ot;
endmodule
`default_nettype wire

//--- logic/duty_output.sv
`timescale 1ns/1ns
`default_nettype none
`include "temp_loop_defs.svh"
module duty_output (
  input  wire logic  ref_clk,
  input  wire logic  rst,
  loop_link_if.pwm   link,
  output logic [3:0] out_main,
  output logic [3:0] out_cool
);
  typedef struct packed {
    logic [9:0]       phase;
    logic [3:0][10:0] lat_h;
    logic [3:0][10:0] lat_c;
    logic [3:0]       oh;
    logic [3:0]       oc;
    logic             pk;
  } pwm_state_t;
  pwm_state_t s_r, s_nxt;
  // Staggered phase per channel so turn-on edges land a quarter period apart
  function automatic logic [9:0] phase_of(input logic [9:0] ph, input logic [1:0] i,
                                          input logic pk);
    logic [10:0] s;
    s = {1'b0, ph} + (pk ? 11'(i) * 11'(`OUT_STAGGER) : 11'h0);
    if (s > 11'(`OUT_LAST)) s = s - 11'(`OUT_PERIOD);
    return s[9:0];
  endfunction
  always_comb begin
    logic [9:0] p;
    p     = 10'h0;
    s_nxt = s_r;
    if (link.ce) begin
      s_nxt.pk = link.peak_sup;
      if (link.out_tick) begin
        s_nxt.phase = (s_r.phase == `OUT_LAST) ? 10'h0 : s_r.phase + 10'h1;
        for (int i = 0; i < 4; i++) begin
          p = phase_of(s_nxt.phase, 2'(i), link.peak_sup);
          // Duty latched only at period start: outputs can only rise there
          if (p == 10'h0) begin
            s_nxt.lat_h[i] = link.duty_h[i];
            s_nxt.lat_c[i] = link.duty_c[i];
          end
          s_nxt.oh[i] = {1'b0, p} < s_nxt.lat_h[i];
          s_nxt.oc[i] = {1'b0, p} < s_nxt.lat_c[i];
        end
      end
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign out_main = s_r.oh;
  assign out_cool = s_r.oc;
  a_stagger_rise: assert property (@(posedge ref_clk) disable iff (rst || !link.ce)
    (s_r.pk && $past(s_r.pk)) |-> $onehot0({s_r.oh, s_r.oc} & ~$past({s_r.oh, s_r.oc})))
    else $error("two channel outputs turned on together");
endmodule
`default_nettype wire

//--- logic/temp_loop_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "temp_loop_defs.svh"
module temp_loop_ctrl #(
  parameter int unsigned FAST_SAMPLE_CYC = `FAST_SAMPLE_CYC,
  parameter int unsigned SLOW_SAMPLE_CYC = `SLOW_SAMPLE_CYC,
  parameter int unsigned OUT_TICK_CYC    = `OUT_TICK_CYC
) (
  input  wire logic                             ref_clk,
  input  wire logic                             rst,
  input  wire logic                             ce,
  input  wire logic                             input_only,
  input  wire logic                             sample_slow,
  input  wire logic                             peak_suppress,
  input  wire logic                             rise_en,
  input  wire logic [3:0]                       rise_group,
  input  wire logic                             nv_save,
  input  wire logic                             nv_busy,
  input  wire logic [3:0][15:0]                 raw_temp,
  input  wire logic [3:0][15:0]                 target_temperature,
  input  wire temp_loop_pkg::ctl_mode_t [3:0]   ctl_mode,
  input  wire temp_loop_pkg::resp_t [3:0]       resp_mode,
  input  wire temp_loop_pkg::comp_t [3:0]       comp_mode,
  input  wire logic [3:0][15:0]                 full_scale,
  input  wire logic [3:0][15:0]                 comp_rate,
  input  wire logic [3:0][15:0]                 cal_meas,
  input  wire logic [3:0][15:0]                 cal_true,
  input  wire logic [3:0][15:0]                 cal_slope,
  input  wire logic [3:0][15:0]                 filt_alpha,
  input  wire logic [3:0][15:0]                 kp,
  input  wire logic [3:0][15:0]                 ki,
  input  wire logic [3:0][15:0]                 kd_a,
  input  wire logic [3:0][15:0]                 kd_b,
  output logic [3:0]                            out_main,
  output logic [3:0]                            out_cool,
  output logic [3:0][15:0]                      measured_temperature,
  output logic [3:0][15:0]                      control_output_level,
  output logic [3:0][15:0]                      cool_output_level,
  output logic                                  cycle_done,
  output logic                                  nv_save_req,
  output logic                                  nv_load_req
);
  typedef struct packed {
    temp_loop_pkg::seq_state_t st;
    logic [1:0]                ch;
    logic [15:0]               pv_c;
    logic [31:0]               mv_raw;
    logic [3:0][15:0]          pv_filt;
    logic [3:0][15:0]          pv_prev;
    logic [3:0][15:0]          mv_h;
    logic [3:0][15:0]          mv_c;
    logic [3:0][15:0]          rise_base;
    logic [3:0][31:0]          integ;
    logic [3:0][31:0]          deriv;
    logic [3:0][10:0]          duty_h;
    logic [3:0][10:0]          duty_c;
    logic [3:0]                primed;
    logic [6:0]                rise_k;
    logic                      rise_q;
    logic [1:0]                busy_s;
    logic                      save_pend;
    logic                      booted;
    logic                      save_req;
    logic                      load_req;
    logic                      done;
  } core_state_t;

  core_state_t s_r, s_nxt;
  loop_link_if link ();

  function automatic logic signed [31:0] sx(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction

  function automatic logic signed [31:0] mulsh(input logic signed [31:0] a,
                                               input logic signed [15:0] b,
                                               input int sh);
    logic signed [47:0] q;
    q = (48'(a) * 48'(b)) >>> sh;
    return q[31:0];
  endfunction

  function automatic logic [15:0] sat(input logic signed [31:0] v);
    if (v < `MV_LO) return 16'(`MV_LO);
    if (v > `MV_HI) return 16'(`MV_HI);
    return v[15:0];
  endfunction

  // Negative levels give no on-time; above 100 % the output stays on
  function automatic logic [10:0] duty_of(input logic [15:0] lv);
    if (lv[15]) return 11'h0;
    if (lv > 16'(`OUT_PERIOD)) return 11'(`OUT_PERIOD);
    return lv[10:0];
  endfunction

  always_comb begin
    logic [1:0]         c;
    logic signed [31:0] pv, sv, base, e, ew, dpv, p, dt, iq, dq, r, lo;
    logic               hc;
    c     = s_r.ch;
    pv    = sx(s_r.pv_filt[c]);
    sv    = sx(target_temperature[c]);
    base  = sx(s_r.rise_base[c]);
    hc    = ctl_mode[c] == temp_loop_pkg::CM_HEATCOOL;
    r     = $signed(s_r.mv_raw);
    lo    = hc ? -`MV_HI : `MV_LO;
    iq    = 32'sh0;
    dq    = 32'sh0;
    dt    = 32'sh0;
    s_nxt = s_r;
    if (rise_en && rise_group[c]) begin
      // Common step count for the group makes every loop arrive together
      sv = base + mulsh(sv - base, {9'h0, s_r.rise_k}, `RISE_SH);
    end
    e = sv - pv;
    unique case (resp_mode[c])
      temp_loop_pkg::RESP_NORMAL: ew = sv - (sv >>> 2) - pv;
      temp_loop_pkg::RESP_SLOW:   ew = (sv >>> 1) - pv;
      default:                    ew = e;
    endcase
    dpv = sx(s_r.pv_prev[c]) - pv;
    if (ctl_mode[c] == temp_loop_pkg::CM_COOL) begin
      e   = -e;
      ew  = -ew;
      dpv = -dpv;
    end
    p = mulsh(ew, kp[c], `KP_SH);
    if (ce) begin
      // Pulses also freeze while the clock enable is low
      s_nxt.done     = 1'b0;
      s_nxt.save_req = 1'b0;
      s_nxt.load_req = 1'b0;
      s_nxt.busy_s = {s_r.busy_s[0], nv_busy};
      if (!s_r.booted) begin
        s_nxt.booted   = 1'b1;
        s_nxt.load_req = 1'b1;
      end
      if (nv_save) s_nxt.save_pend = 1'b1;
      if (s_r.save_pend && !s_r.busy_s[1]) begin
        s_nxt.save_req  = 1'b1;
        s_nxt.save_pend = nv_save;
      end
      s_nxt.rise_q = rise_en;
      if (rise_en && !s_r.rise_q) begin
        s_nxt.rise_k    = 7'h0;
        s_nxt.rise_base = s_r.pv_filt;
      end
      unique case (s_r.st)
        temp_loop_pkg::ST_IDLE: begin
          if (link.sample_tick) begin
            s_nxt.st = temp_loop_pkg::ST_COMP;
            s_nxt.ch = 2'h0;
          end
        end
        temp_loop_pkg::ST_COMP: begin
          unique case (comp_mode[c])
            temp_loop_pkg::COMP_ONE_PT: begin
              s_nxt.pv_c = 16'(sx(raw_temp[c]) + mulsh(sx(full_scale[c]), comp_rate[c],
                                                        `Q15_SH));
            end
            temp_loop_pkg::COMP_TWO_PT: begin
              s_nxt.pv_c = 16'(sx(cal_true[c]) + mulsh(sx(raw_temp[c]) - sx(cal_meas[c]),
                                                        cal_slope[c], `KP_SH));
            end
            default: s_nxt.pv_c = raw_temp[c];
          endcase
          s_nxt.st = temp_loop_pkg::ST_FILT;
        end
        temp_loop_pkg::ST_FILT: begin
          if (!s_r.primed[c] || filt_alpha[c] == 16'h0) begin
            s_nxt.pv_filt[c] = s_r.pv_c;
          end else begin
            s_nxt.pv_filt[c] = 16'(pv + mulsh(sx(s_r.pv_c) - pv, filt_alpha[c],
                                              `Q15_SH));
          end
          // First sample seeds history so the derivative starts from rest
          if (!s_r.primed[c]) s_nxt.pv_prev[c] = s_r.pv_c;
          s_nxt.primed[c] = 1'b1;
          s_nxt.st = input_only ? temp_loop_pkg::ST_OUT : temp_loop_pkg::ST_PID;
        end
        temp_loop_pkg::ST_PID: begin
          s_nxt.integ[c] = s_r.integ[c] + mulsh(e, ki[c], 0);
          dt = mulsh(dpv, kp[c], `KP_SH) <<< `ACC_SH;
          dq = $signed(s_r.deriv[c]);
          dq = dq + mulsh(dt - mulsh(dq, kd_b[c], `Q15_SH), kd_a[c], `Q15_SH);
          s_nxt.deriv[c] = dq;
          iq = $signed(s_nxt.integ[c]);
          s_nxt.mv_raw = p + (iq >>> `ACC_SH) + (dq >>> `ACC_SH);
          s_nxt.pv_prev[c] = s_r.pv_filt[c];
          s_nxt.st = temp_loop_pkg::ST_CLAMP;
        end
        temp_loop_pkg::ST_CLAMP: begin
          if (r > `MV_HI) begin
            s_nxt.integ[c] = s_r.integ[c] - ((r - `MV_HI) <<< `ACC_SH);
          end else if (r < lo) begin
            s_nxt.integ[c] = s_r.integ[c] + ((lo - r) <<< `ACC_SH);
          end
          s_nxt.mv_h[c] = sat(r);
          s_nxt.mv_c[c] = hc ? sat(-r) : 16'h0;
          s_nxt.st = temp_loop_pkg::ST_OUT;
        end
        temp_loop_pkg::ST_OUT: begin
          s_nxt.duty_h[c] = input_only ? 11'h0 : duty_of(s_r.mv_h[c]);
          s_nxt.duty_c[c] = (input_only || !hc) ? 11'h0 : duty_of(s_r.mv_c[c]);
          if (c == 2'h3) begin
            s_nxt.st   = temp_loop_pkg::ST_IDLE;
            s_nxt.done = 1'b1;
            if (s_r.rise_k < `RISE_STEPS) s_nxt.rise_k = s_r.rise_k + 7'h1;
          end else begin
            s_nxt.ch = c + 2'h1;
            s_nxt.st = temp_loop_pkg::ST_COMP;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_r    <= '0;
      s_r.st <= temp_loop_pkg::ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.ce       = ce;
  assign link.slow_sel = sample_slow;
  assign link.peak_sup = peak_suppress;
  assign link.duty_h   = s_r.duty_h;
  assign link.duty_c   = s_r.duty_c;

  sample_timer #(
    .FAST_CYC (FAST_SAMPLE_CYC),
    .SLOW_CYC (SLOW_SAMPLE_CYC),
    .TICK_CYC (OUT_TICK_CYC)
  ) u_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .link    (link.timer)
  );

  duty_output u_duty (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .link     (link.pwm),
    .out_main (out_main),
    .out_cool (out_cool)
  );

  assign measured_temperature = s_r.pv_filt;
  assign control_output_level = s_r.mv_h;
  assign cool_output_level    = s_r.mv_c;
  assign cycle_done           = s_r.done;
  assign nv_save_req          = s_r.save_req;
  assign nv_load_req          = s_r.load_req;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst || !ce);

  sequence s_pid_path;
    s_r.st == temp_loop_pkg::ST_PID ##1 s_r.st == temp_loop_pkg::ST_CLAMP
      ##1 s_r.st == temp_loop_pkg::ST_OUT;
  endsequence

  a_step_order: assert property (
    (s_r.st == temp_loop_pkg::ST_COMP) ##1 !input_only
      |-> s_r.st == temp_loop_pkg::ST_FILT ##1 s_pid_path)
    else $error("channel steps out of order");

  a_cycle_bound: assert property (
    (s_r.st == temp_loop_pkg::ST_IDLE && link.sample_tick) |-> ##[13:21] s_r.done)
    else $error("four channels not processed in time");

  a_level_range: assert property (
    (s_r.st == temp_loop_pkg::ST_OUT)
      |-> ($signed(s_r.mv_h[s_r.ch]) >= 16'sh7fce - 16'sh7fce - 16'sh0032
           && $signed(s_r.mv_h[s_r.ch]) <= 16'sh041a))
    else $error("output level outside clamp range");

  a_split_outputs: assert property (
    (s_r.st == temp_loop_pkg::ST_OUT)
      |=> !(|s_r.duty_h[$past(s_r.ch)] && |s_r.duty_c[$past(s_r.ch)]))
    else $error("heating and cooling both active");

  a_input_only: assert property (
    (s_r.st == temp_loop_pkg::ST_OUT && input_only)
      |=> (s_r.duty_h[$past(s_r.ch)] == 11'h0 && s_r.duty_c[$past(s_r.ch)] == 11'h0))
    else $error("output duty set in input-only mode");

  a_filter_bypass: assert property (
    (s_r.st == temp_loop_pkg::ST_FILT && filt_alpha[s_r.ch] == 16'h0)
      |=> s_r.pv_filt[$past(s_r.ch)] == $past(s_r.pv_c))
    else $error("unfiltered temperature not passed through");

  a_nv_save: assert property (
    (nv_save && !s_r.busy_s[0] && !s_r.busy_s[1]) |-> ##2 nv_save_req)
    else $error("save request not issued");
endmodule
`default_nettype wire

//--- logic/unused_placeholder_removed.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

//--- sim/thermal_plant.sv
`timescale 1ns/1ns
`default_nettype none
module thermal_plant (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             hold,
  input  wire logic [3:0]       out_main,
  input  wire logic [3:0]       out_cool,
  output logic      [3:0][15:0] raw_temp
);
  logic [7:0] div_r;
  // Slow drift keeps each sample cycle's input nearly steady
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_r <= 8'h00;
      raw_temp <= {4{16'h00c8}};
    end else begin
      div_r <= div_r + 8'h01;
      if (!hold && div_r == 8'hff) begin
        for (int i = 0; i < 4; i++) begin
          raw_temp[i] <= raw_temp[i] + {15'h0000, out_main[i]} - {15'h0000, out_cool[i]};
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- sim/four_loop_pid_temp_controller_tb.sv
`timescale 1ns/1ns
`default_nettype none
module four_loop_pid_temp_controller_tb;
  logic                           ref_clk, rst, ce, input_only, sample_slow, peak_suppress;
  logic                           rise_en, nv_save, nv_busy, hold;
  logic [3:0]                     rise_group, out_main, out_cool, prev_main;
  logic [3:0][15:0]               raw_temp, target_temperature, full_scale, comp_rate;
  logic [3:0][15:0]               cal_meas, cal_true, cal_slope, filt_alpha, kp, ki, kd_a, kd_b;
  logic [3:0][15:0]               measured_temperature, control_output_level, cool_output_level;
  temp_loop_pkg::ctl_mode_t [3:0] ctl_mode;
  temp_loop_pkg::resp_t [3:0]     resp_mode;
  temp_loop_pkg::comp_t [3:0]     comp_mode;
  logic                           cycle_done, nv_save_req, nv_load_req;
  int                             bad_count, checked, n;

  temp_loop_ctrl #(.FAST_SAMPLE_CYC(200), .SLOW_SAMPLE_CYC(400), .OUT_TICK_CYC(2)) u_temp_loop_ctrl (
    .ref_clk, .rst, .ce, .input_only, .sample_slow, .peak_suppress, .rise_en, .rise_group,
    .nv_save, .nv_busy, .raw_temp, .target_temperature, .ctl_mode, .resp_mode, .comp_mode,
    .full_scale, .comp_rate, .cal_meas, .cal_true, .cal_slope, .filt_alpha, .kp, .ki,
    .kd_a, .kd_b, .out_main, .out_cool, .measured_temperature, .control_output_level,
    .cool_output_level, .cycle_done, .nv_save_req, .nv_load_req);

  thermal_plant u_thermal_plant (.ref_clk, .rst, .hold, .out_main, .out_cool, .raw_temp);

  always #2 ref_clk = ~ref_clk;

  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk4(input string nm, input logic [3:0] e, input logic [3:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude();
    $display("Counts: checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Returns the edge count of the last wait, bounded
  task automatic wait_done(input int cnt, output int k);
    for (int j = 0; j < cnt; j++) begin
      k = 0;
      do begin
        @(posedge ref_clk);
        k++;
      end while (cycle_done !== 1'b1 && k < 1000);
      if (k >= 1000) begin
        bad_count++;
        $display("Error cycle_done expected 1 seen 0");
      end
    end
  endtask

  task automatic cfg(input temp_loop_pkg::ctl_mode_t m, input logic [15:0] d);
    @(posedge ref_clk);
    for (int i = 0; i < 4; i++) begin
      ctl_mode[i] <= m;
      target_temperature[i] <= raw_temp[i] + d;
      resp_mode[i] <= temp_loop_pkg::resp_t'($urandom_range(2));
    end
  endtask

  function automatic logic [15:0] exp_pv(input int c, input int i);
    logic signed [31:0] t;
    t = 32'($signed(raw_temp[i] - cal_meas[i])) * $signed(32'(cal_slope[i]));
    case (c)
      0: return raw_temp[i];
      1: return raw_temp[i] + 16'((32'(full_scale[i]) * 32'(comp_rate[i])) >> 15);
      default: return cal_true[i] + 16'(t >>> 8);
    endcase
  endfunction

  // Staggered turn-on: never two out_main outputs rising together
  always @(posedge ref_clk) begin
    prev_main <= out_main;
    if (!rst && peak_suppress && |(out_main & ~prev_main)) begin
      checked++;
      if ($countones(out_main & ~prev_main) > 1) begin
        bad_count++;
        $display("Error out_main turn-on expected one seen %b", out_main & ~prev_main);
      end
    end
  end

  initial begin
    #(4 * 80000);
    bad_count++;
    $display("Error watchdog expected finish seen timeout");
    conclude();
  end

  initial begin
    void'($urandom(32'h2fb90db9));
    {ref_clk, rst, ce, input_only, sample_slow, peak_suppress} = 6'b011000;
    {rise_en, nv_save, nv_busy, hold, rise_group} = 8'h00;
    bad_count = 0;
    checked = 0;
    for (int i = 0; i < 4; i++) begin
      ctl_mode[i] = temp_loop_pkg::CM_HEAT;
      resp_mode[i] = temp_loop_pkg::RESP_NORMAL;
      comp_mode[i] = temp_loop_pkg::COMP_NONE;
      {target_temperature[i], full_scale[i], comp_rate[i], cal_meas[i]} = 64'h0;
      {cal_true[i], cal_slope[i], filt_alpha[i]} = 48'h0;
      kp[i] = 16'h7fff;
      ki[i] = 16'($urandom_range(255));
      kd_a[i] = 16'($urandom_range(4095));
      kd_b[i] = 16'($urandom_range(4095));
    end
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    n = 0;
    repeat (6) begin
      @(posedge ref_clk);
      #1 n += int'(nv_load_req);
    end
    chk16("nv_load_req pulses", 16'h0001, 16'(n));
    $display("Test reset load done");
    for (int s = 0; s < 2; s++) begin
      sample_slow <= s[0];
      wait_done(2, n);
      wait_done(1, n);
      chk16("sample spacing", s[0] ? 16'h0190 : 16'h00c8, 16'(n));
    end
    sample_slow <= 1'b0;
    $display("Test sample cycle done");
    peak_suppress <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      cfg(k < 2 ? temp_loop_pkg::CM_HEAT : temp_loop_pkg::CM_COOL,
          (k == 0 || k == 3) ? 16'h03e8 : 16'hfc18);
      repeat (5000) @(posedge ref_clk);
      for (int i = 0; i < 4; i++) begin
        chk16("control_output_level", k[0] ? 16'hffce : 16'h041a, control_output_level[i]);
      end
      chk4("out_main", k[0] ? 4'h0 : 4'hf, out_main);
    end
    $display("Test action and clamp done");
    for (int h = 0; h < 2; h++) begin
      cfg(temp_loop_pkg::CM_HEATCOOL, h[0] ? 16'h03e8 : 16'hfc18);
      repeat (5000) @(posedge ref_clk);
      chk4("out_main", h[0] ? 4'hf : 4'h0, out_main);
      chk4("out_cool", h[0] ? 4'h0 : 4'hf, out_cool);
      for (int i = 0; i < 4; i++) begin
        chk16("cool_output_level", h[0] ? 16'hffce : 16'h041a, cool_output_level[i]);
      end
    end
    peak_suppress <= 1'b0;
    $display("Test heat-cool done");
    hold <= 1'b1;
    for (int c = 0; c < 3; c++) begin
      @(posedge ref_clk);
      for (int i = 0; i < 4; i++) begin
        comp_mode[i] <= temp_loop_pkg::comp_t'(c);
        full_scale[i] <= 16'($urandom_range(1000)) << 1;
        comp_rate[i] <= 16'h4000;
        cal_meas[i] <= (i == 0) ? raw_temp[i] : 16'($urandom_range(400));
        cal_true[i] <= 16'($urandom_range(400));
        cal_slope[i] <= 16'h0100 << $urandom_range(1);
      end
      wait_done(2, n);
      for (int i = 0; i < 4; i++) begin
        chk16("measured_temperature", exp_pv(c, i), measured_temperature[i]);
      end
    end
    hold <= 1'b0;
    $display("Test compensation done");
    input_only <= 1'b1;
    cfg(temp_loop_pkg::CM_HEATCOOL, 16'hfc18);
    repeat (5000) @(posedge ref_clk);
    chk4("out_main input only", 4'h0, out_main | out_cool);
    input_only <= 1'b0;
    $display("Test input only done");
    nv_busy <= 1'b1;
    // Busy must pass the two-stage synchroniser before the command
    repeat (3) @(posedge ref_clk);
    nv_save <= 1'b1;
    @(posedge ref_clk);
    nv_save <= 1'b0;
    for (int b = 0; b < 2; b++) begin
      n = 0;
      repeat (10) begin
        @(posedge ref_clk);
        #1 n += int'(nv_save_req);
      end
      chk16("nv_save_req pulses", b ? 16'h0001 : 16'h0000, 16'(n));
      nv_busy <= 1'b0;
    end
    @(posedge ref_clk);
    nv_save <= 1'b1;
    n = 0;
    for (int i = 1; i < 5; i++) begin
      @(posedge ref_clk);
      if (i == 1) nv_save <= 1'b0;
      #1 if (nv_save_req === 1'b1) n = i;
    end
    chk16("nv_save_req latency", 16'h0002, 16'(n));
    $display("Test save done");
    conclude();
  end
endmodule
`default_nettype wire
